// ---- design/hfa_pkg.sv ----
// Purpose: Shared types and constants of the hex float datapath.
// Assumes: Bit 0 of the documented format is the MSB of each word.
// Notes:   Working fractions are 64-bit signed, value = w / 2**60.
package hfa_pkg;

  // Working fraction and unbiased exponent types.
  typedef logic signed [63:0] hfa_frac_t;
  typedef logic signed [8:0]  hfa_exp_t;

  // Operation codes.
  typedef enum logic [1:0] {
    HFA_ADD = 2'b00,
    HFA_SUB = 2'b01,
    HFA_MUL = 2'b10
  } hfa_op_e;

  // Sequencer states.
  typedef enum logic [2:0] {
    HFA_IDLE  = 3'b000,
    HFA_ALIGN = 3'b001,
    HFA_COMB  = 3'b010,
    HFA_NORM  = 3'b011,
    HFA_ROUND = 3'b100,
    HFA_PACK  = 3'b101
  } hfa_state_e;

  // Condition-code flags.
  typedef struct packed {
    logic exception_flag;
    logic positive_flag;
    logic negative_flag;
    logic zero_position_flag;
  } hfa_flags_s;

  // Unpacked operand.
  typedef struct packed {
    hfa_frac_t frac;
    hfa_exp_t  exp;
  } hfa_opnd_s;

  // Field positions in the 64-bit operand (first register on top).
  localparam int SIGN_POS = 63;
  localparam int EXP_HI   = 62;
  localparam int EXP_LO   = 56;
  localparam int SW_SHIFT = 36;
  localparam int DW_SHIFT = 4;

  // Exponent bias and limits.
  localparam hfa_exp_t EXP_BIAS = 9'sh040;
  localparam hfa_exp_t EXP_MAX  = 9'sh07F;
  localparam hfa_exp_t EXP_ONE  = 9'sh001;
  localparam hfa_exp_t SW_FAR   = 9'sh006;
  localparam hfa_exp_t DW_FAR   = 9'sh00D;

  // Fraction magnitudes in working scale.
  localparam hfa_frac_t FR_ONE   = 64'sh1000_0000_0000_0000;
  localparam hfa_frac_t FR_SIXTH = 64'sh0100_0000_0000_0000;
  localparam hfa_frac_t RND_BIT  = 64'sh0000_0008_0000_0000;
  localparam hfa_frac_t RND_MASK = 64'shFFFF_FFF0_0000_0000;

  // Reset values.
  localparam logic [63:0] RESULT_RST = 64'h0000_0000_0000_0000;
  localparam logic [3:0]  FLAGS_RST  = 4'h0;

endpackage : hfa_pkg

// ---- design/hfa_unit.sv ----
// Purpose: Base-16 float add, subtract and single multiply datapath.
// Assumes: Operands are normalised; inputs come from the CLK domain.
// Notes:   Multi-cycle; one hex digit of shift per cycle.
// Function
// - Non-zero results lie in normalised fraction range; a double just above minus one truncates to minus one.
// - Minus one becomes exponent-adjusted F digit form.
// - Single operands carry a hex guard digit.
// - Single results round on guard digit MSB.
// - Negative operand exponents are one's complemented.
// - Unbias exponents; equal exponents combine directly.
// - Shift smaller operand one digit per step.
// - Single difference above six returns larger operand.
// - Double difference above 13 returns larger operand.
// - Zero fraction gives all-zero exponent and fraction.
// - Single result packs sign, exponent, 24-bit fraction.
// - Double result packs 56-bit fraction across pair.
// - Subtract memory operand from register operand.
// - Multiply fractions, add exponents, normalise, round.
// - Set exception, or exactly one sign flag.
// - Overflow adds zero flag; sign flag still shown.
// - Sign bit, 7-bit excess-64 exponent, hex fraction.
// - Negatives are two's complement of whole word.
`timescale 1ns/1ps
module hfa_unit (
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire logic                 CE,
  input  wire logic                 START,
  input  wire hfa_pkg::hfa_op_e     OP,
  input  wire logic                 DBL,
  input  wire logic [63:0]          GENERAL_REGISTER,
  input  wire logic [63:0]          MEMORY_OPERAND_WORD,
  output logic      [63:0]          RESULT,
  output hfa_pkg::hfa_flags_s       FLAGS,
  output logic                      BUSY,
  output logic                      DONE
);

  hfa_pkg::hfa_state_e st_r, st_nxt;
  hfa_pkg::hfa_op_e    op_r, op_nxt;
  logic                dbl_r, dbl_nxt;
  logic                rnd_r, rnd_nxt;
  hfa_pkg::hfa_frac_t  wa_r, wa_nxt;
  hfa_pkg::hfa_frac_t  wb_r, wb_nxt;
  hfa_pkg::hfa_exp_t   ea_r, ea_nxt;
  hfa_pkg::hfa_exp_t   eb_r, eb_nxt;
  logic [63:0]         res_r, res_nxt;
  hfa_pkg::hfa_flags_s flg_r, flg_nxt;
  logic                done_r, done_nxt;

  hfa_pkg::hfa_opnd_s  reg_op;
  hfa_pkg::hfa_opnd_s  mem_op;
  logic                dbl_in;
  hfa_pkg::hfa_exp_t   diff;
  hfa_pkg::hfa_exp_t   adiff;
  logic                far;
  logic signed [49:0]  prod;
  hfa_pkg::hfa_frac_t  prod_w;
  hfa_pkg::hfa_exp_t   ebias;
  logic                neg;
  logic                ovf;
  logic                unf;
  logic                zero;
  logic [6:0]          expf;
  logic [55:0]         frac56;

  // True when the fraction is at or above magnitude one.
  function automatic logic too_big(input hfa_pkg::hfa_frac_t w);
    too_big = (w >= hfa_pkg::FR_ONE) || (w <= -hfa_pkg::FR_ONE);
  endfunction : too_big

  // True when the leading hex digit carries no significance.
  function automatic logic too_small(input hfa_pkg::hfa_frac_t w);
    too_small = (w < hfa_pkg::FR_SIXTH) && (w > -hfa_pkg::FR_SIXTH);
  endfunction : too_small

  // Multiply is single-word only.
  assign dbl_in = DBL && (OP != hfa_pkg::HFA_MUL);

  hfa_unpack u_reg (
    .word (GENERAL_REGISTER),
    .dbl  (dbl_in),
    .opnd (reg_op)
  );

  hfa_unpack u_mem (
    .word (MEMORY_OPERAND_WORD),
    .dbl  (dbl_in),
    .opnd (mem_op)
  );

  // Exponent distance and the product of the two 25-bit fractions.
  always_comb begin
    diff   = reg_op.exp - mem_op.exp;
    adiff  = diff[8] ? -diff : diff;
    far    = adiff > (dbl_in ? hfa_pkg::DW_FAR : hfa_pkg::SW_FAR);
    // Both fractions are signed, so a negative operand must multiply signed.
    prod   = $signed(wa_r[60:36]) * $signed(wb_r[60:36]);
    prod_w = $signed({{2{prod[49]}}, prod, 12'h000});
  end

  // Packing of the working result.
  always_comb begin
    ebias  = ea_r + hfa_pkg::EXP_BIAS;
    zero   = (wa_r == 64'sh0000_0000_0000_0000);
    neg    = wa_r[63];
    ovf    = !zero && (ebias > hfa_pkg::EXP_MAX);
    unf    = !zero && ebias[8];
    expf   = neg ? ~ebias[6:0] : ebias[6:0];
    frac56 = dbl_r ? wa_r[59:4] : {wa_r[59:36], 32'h0000_0000};
  end

  // Next-state logic of the sequencer and datapath.
  always_comb begin
    st_nxt   = st_r;
    op_nxt   = op_r;
    dbl_nxt  = dbl_r;
    rnd_nxt  = rnd_r;
    wa_nxt   = wa_r;
    wb_nxt   = wb_r;
    ea_nxt   = ea_r;
    eb_nxt   = eb_r;
    res_nxt  = res_r;
    flg_nxt  = flg_r;
    done_nxt = 1'b0;
    case (st_r)
      hfa_pkg::HFA_IDLE: begin
        if (START) begin
          op_nxt  = OP;
          dbl_nxt = dbl_in;
          rnd_nxt = 1'b0;
          wa_nxt  = reg_op.frac;
          ea_nxt  = reg_op.exp;
          eb_nxt  = mem_op.exp;
          // Subtract negates the memory operand up front.
          wb_nxt  = (OP == hfa_pkg::HFA_SUB) ? -mem_op.frac
                                             : mem_op.frac;
          if (OP == hfa_pkg::HFA_MUL) begin
            st_nxt = hfa_pkg::HFA_COMB;
          end else if (far) begin
            // Skip the arithmetic and keep the larger operand.
            st_nxt = hfa_pkg::HFA_NORM;
            if (diff[8]) begin
              wa_nxt = (OP == hfa_pkg::HFA_SUB) ? -mem_op.frac
                                                : mem_op.frac;
              ea_nxt = mem_op.exp;
            end
          end else begin
            st_nxt = hfa_pkg::HFA_ALIGN;
          end
        end
      end
      hfa_pkg::HFA_ALIGN: begin
        // One hex digit per cycle until exponents match.
        if (ea_r < eb_r) begin
          wa_nxt = wa_r >>> 4;
          ea_nxt = ea_r + hfa_pkg::EXP_ONE;
        end else if (eb_r < ea_r) begin
          wb_nxt = wb_r >>> 4;
          eb_nxt = eb_r + hfa_pkg::EXP_ONE;
        end else begin
          st_nxt = hfa_pkg::HFA_COMB;
        end
      end
      hfa_pkg::HFA_COMB: begin
        if (op_r == hfa_pkg::HFA_MUL) begin
          wa_nxt = prod_w;
          ea_nxt = ea_r + eb_r;
        end else begin
          wa_nxt = wa_r + wb_r;
        end
        st_nxt = hfa_pkg::HFA_NORM;
      end
      hfa_pkg::HFA_NORM: begin
        if (wa_r == 64'sh0000_0000_0000_0000) begin
          st_nxt = hfa_pkg::HFA_PACK;
        end else if (too_big(wa_r)) begin
          // Carry out, or exactly minus one, moves right a digit.
          wa_nxt = wa_r >>> 4;
          ea_nxt = ea_r + hfa_pkg::EXP_ONE;
        end else if (too_small(wa_r)) begin
          wa_nxt = wa_r <<< 4;
          ea_nxt = ea_r - hfa_pkg::EXP_ONE;
        end else if (!dbl_r && !rnd_r) begin
          st_nxt = hfa_pkg::HFA_ROUND;
        end else begin
          st_nxt = hfa_pkg::HFA_PACK;
        end
      end
      hfa_pkg::HFA_ROUND: begin
        // Rounding may carry out, so normalise once more.
        wa_nxt  = (wa_r + hfa_pkg::RND_BIT) & hfa_pkg::RND_MASK;
        rnd_nxt = 1'b1;
        st_nxt  = hfa_pkg::HFA_NORM;
      end
      hfa_pkg::HFA_PACK: begin
        res_nxt  = zero ? 64'h0000_0000_0000_0000
                        : {neg, expf, frac56};
        flg_nxt.exception_flag     = ovf || unf;
        flg_nxt.positive_flag      = !zero && !neg;
        flg_nxt.negative_flag      = !zero && neg;
        flg_nxt.zero_position_flag = zero || ovf;
        done_nxt = 1'b1;
        st_nxt   = hfa_pkg::HFA_IDLE;
      end
      default: begin
        st_nxt = hfa_pkg::HFA_IDLE;
      end
    endcase
  end

  // State registers, frozen while CE is low.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_r   <= hfa_pkg::HFA_IDLE;
      op_r   <= hfa_pkg::HFA_ADD;
      dbl_r  <= 1'b0;
      rnd_r  <= 1'b0;
      wa_r   <= 64'sh0000_0000_0000_0000;
      wb_r   <= 64'sh0000_0000_0000_0000;
      ea_r   <= 9'sh000;
      eb_r   <= 9'sh000;
      res_r  <= hfa_pkg::RESULT_RST;
      flg_r  <= hfa_pkg::FLAGS_RST;
      done_r <= 1'b0;
    end else if (CE) begin
      st_r   <= st_nxt;
      op_r   <= op_nxt;
      dbl_r  <= dbl_nxt;
      rnd_r  <= rnd_nxt;
      wa_r   <= wa_nxt;
      wb_r   <= wb_nxt;
      ea_r   <= ea_nxt;
      eb_r   <= eb_nxt;
      res_r  <= res_nxt;
      flg_r  <= flg_nxt;
      done_r <= done_nxt;
    end
  end

  // Outputs.
  assign RESULT = res_r;
  assign FLAGS  = flg_r;
  assign DONE   = done_r;
  assign BUSY   = (st_r != hfa_pkg::HFA_IDLE);

  // Checks on the datapath, disabled during reset and while CE is low.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N || !CE);

  chk_flags_onehot: assert property (
    DONE && !FLAGS.exception_flag |-> $onehot({FLAGS.positive_flag,
      FLAGS.negative_flag, FLAGS.zero_position_flag}))
    else $error("sign flags not exactly one");

  chk_exc_sign: assert property (
    DONE && FLAGS.exception_flag |->
      (FLAGS.positive_flag ^ FLAGS.negative_flag))
    else $error("exception without one sign flag");

  chk_zero_pack: assert property (
    DONE && FLAGS.zero_position_flag && !FLAGS.exception_flag
      |-> RESULT == 64'h0000_0000_0000_0000)
    else $error("zero result not cleared");

  chk_no_minus_one: assert property (
    DONE && RESULT[63] |-> RESULT[55:0] != 56'h00_0000_0000_0000)
    else $error("minus one fraction delivered");

  chk_norm_digit: assert property (
    DONE && !RESULT[63] && !FLAGS.zero_position_flag
      |-> RESULT[55:52] != 4'h0)
    else $error("positive result not normalised");

  chk_align_step: assert property (
    st_r == hfa_pkg::HFA_ALIGN && ea_r < eb_r
      |=> ea_r == $past(ea_r) + hfa_pkg::EXP_ONE && eb_r == $past(eb_r))
    else $error("alignment step wrong");

  chk_skip_far: assert property (
    st_r == hfa_pkg::HFA_IDLE && START && OP != hfa_pkg::HFA_MUL && far
      |=> st_r == hfa_pkg::HFA_NORM)
    else $error("far operand not passed through");

  chk_round_clear: assert property (
    st_r == hfa_pkg::HFA_ROUND |=> wa_r[35:0] == 36'h0_0000_0000)
    else $error("guard digit not rounded away");

  chk_exp_pack: assert property (
    st_r == hfa_pkg::HFA_PACK && !zero && !dbl_r
      |=> RESULT[62:56] == (RESULT[63] ? ~$past(ebias[6:0])
                                       : $past(ebias[6:0])))
    else $error("exponent field packed wrong");

  chk_done_pulse: assert property (
    DONE |=> !DONE)
    else $error("done longer than one cycle");

  cov_mul_done: cover property (
    st_r == hfa_pkg::HFA_PACK && op_r == hfa_pkg::HFA_MUL);
  cov_sub_double: cover property (
    st_r == hfa_pkg::HFA_PACK && op_r == hfa_pkg::HFA_SUB && dbl_r);
  cov_overflow: cover property (DONE && FLAGS.zero_position_flag
    && FLAGS.exception_flag);
  cov_far_skip: cover property (
    st_r == hfa_pkg::HFA_IDLE && START && far);

endmodule : hfa_unit

// ---- design/hfa_unpack.sv ----
// Purpose: Turns a packed float into a signed fraction and exponent.
// Assumes: Single operands use the upper word only.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module hfa_unpack (
  input  wire logic [63:0]       word,
  input  wire logic              dbl,
  output hfa_pkg::hfa_opnd_s     opnd
);

  logic [6:0] exp_field;
  logic [6:0] exp_true;

  // Complement the exponent of a negative number, then strip the bias.
  always_comb begin
    exp_field = word[hfa_pkg::EXP_HI:hfa_pkg::EXP_LO];
    exp_true  = word[hfa_pkg::SIGN_POS] ? ~exp_field : exp_field;
    opnd.exp  = $signed({2'b00, exp_true}) - hfa_pkg::EXP_BIAS;
    // Sign and fraction form one two's complement number.
    if (dbl) begin
      opnd.frac = $signed({{3{word[63]}}, word[63], word[55:0], 4'h0});
    end else begin
      opnd.frac = $signed({{3{word[63]}}, word[63], word[55:32],
                           36'h0_0000_0000});
    end
  end

endmodule : hfa_unpack

// ---- sim/hfa_cpu_model.sv ----
// Purpose: Behavioural CPU sequencer and operand fetch feeding the unit.
// Assumes: One request at a time; CE and BUSY settle well before an edge.
// Notes:   Operand lines are scrambled once the request has been taken.
`timescale 1ns/1ps
module hfa_cpu_model (
  input  wire logic        clk,
  input  wire logic        ce,
  input  wire logic        busy,
  output logic             start,
  output hfa_pkg::hfa_op_e op,
  output logic             dbl,
  output logic [63:0]      gen_reg,
  output logic [63:0]      mem_word
);
  // Idle request lines at time zero.
  initial begin
    start    = 1'b0;
    op       = hfa_pkg::HFA_ADD;
    dbl      = 1'b0;
    gen_reg  = 64'h0000_0000_0000_0000;
    mem_word = 64'hFFFF_FFFF_FFFF_FFFF;
  end

  // Holds one request until an edge where the unit is idle and enabled.
  task automatic issue(input hfa_pkg::hfa_op_e o, input logic d,
                       input logic [63:0] g, input logic [63:0] m);
    logic ok;
    ok = 1'b0;
    @(posedge clk);
    #1;
    start    = 1'b1;
    op       = o;
    dbl      = d;
    gen_reg  = g;
    mem_word = m;
    while (!ok) begin
      #2;
      ok = (ce === 1'b1) && (busy === 1'b0);
      @(posedge clk);
      #1;
    end
    // Operands are only good at the taking edge, so they change after it.
    start    = 1'b0;
    dbl      = ~d;
    gen_reg  = ~g;
    mem_word = ~m;
  endtask : issue
endmodule : hfa_cpu_model

// ---- sim/hfa_unit_tb_top.sv ----
// Purpose: Self-checking bench for the hex float add, subtract, multiply.
// Assumes: Expected words are worked out by hand from the float format.
// Notes:   Exception cases check flags only, since the result wraps.
`timescale 1ns/1ps
module hfa_unit_tb_top;
  localparam hfa_pkg::hfa_op_e AD = hfa_pkg::HFA_ADD;
  localparam hfa_pkg::hfa_op_e SB = hfa_pkg::HFA_SUB;
  localparam hfa_pkg::hfa_op_e MU = hfa_pkg::HFA_MUL;

  logic                clk;
  logic                rst_n;
  logic                ce;
  logic                start;
  logic                dbl;
  logic                busy;
  logic                done;
  hfa_pkg::hfa_op_e    op;
  logic [63:0]         gen_reg;
  logic [63:0]         mem_word;
  logic [63:0]         result;
  hfa_pkg::hfa_flags_s flags;
  logic                no_res;
  int                  bad_count;
  int                  num_checks;
  int                  cycles;

  hfa_unit uut (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .START(start), .OP(op), .DBL(dbl),
    .GENERAL_REGISTER(gen_reg), .MEMORY_OPERAND_WORD(mem_word),
    .RESULT(result), .FLAGS(flags), .BUSY(busy), .DONE(done)
  );

  hfa_cpu_model cpu (
    .clk(clk), .ce(ce), .busy(busy), .start(start), .op(op), .dbl(dbl),
    .gen_reg(gen_reg), .mem_word(mem_word)
  );

  // Free-running 250 MHz clock.
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // Cuts a hang short well past the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      $display("Error at %0t: run timed out", $time);
      complete_run();
    end
  end

  // Compares a result word.
  task automatic cmp_res(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: result %h expected %h", $time, got, exp);
    end
  endtask : cmp_res

  // Compares the four condition flags.
  task automatic cmp_flg(input hfa_pkg::hfa_flags_s got,
                         input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: flags %b expected %b", $time, got, exp);
    end
  endtask : cmp_flg

  // Compares the busy and done pair.
  task automatic cmp_ctl(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: busy/done %b expected %b", $time, got, exp);
    end
  endtask : cmp_ctl

  // Issues one operation, optionally freezes it, and checks the answer.
  task automatic go(input hfa_pkg::hfa_op_e o, input logic d,
                    input logic [63:0] g, input logic [63:0] m,
                    input logic [63:0] r, input logic [3:0] f,
                    input int stall);
    int n;
    n = 0;
    cpu.issue(o, d, g, m);
    if (stall > 0) begin
      ce = 1'b0;
      repeat (stall) @(posedge clk);
      #1;
      cmp_ctl({busy, done}, 2'b10);
      ce = 1'b1;
    end
    while (done !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp_ctl({busy, done}, 2'b01);
    if (!no_res) begin
      cmp_res(result, r);
    end
    cmp_flg(flags, f);
  endtask : go

  // Single-word operation; the low word of the result must be zero.
  task automatic run(input hfa_pkg::hfa_op_e o, input logic [31:0] g,
                     input logic [31:0] m, input logic [31:0] r,
                     input logic [3:0] f);
    go(o, 1'b0, {g, 32'h0000_0000}, {m, 32'h0000_0000},
       {r, 32'h0000_0000}, f, 0);
  endtask : run

  // Main sequence: reset, then single, double and exception cases.
  initial begin
    ce         = 1'b1;
    rst_n      = 1'b0;
    no_res     = 1'b0;
    bad_count  = 0;
    num_checks = 0;
    cycles     = 0;
    repeat (5) @(posedge clk);
    #1;
    cmp_res(result, 64'h0000_0000_0000_0000);
    cmp_flg(flags, 4'h0);
    cmp_ctl({busy, done}, 2'b00);
    rst_n = 1'b1;
    run(AD, 32'h4180_0000, 32'h4140_0000, 32'h41C0_0000, 4'h4);
    go(AD, 1'b0, 64'h4180_0000_0000_0000, 64'h4140_0000_0000_0000,
       64'h41C0_0000_0000_0000, 4'h4, 3);
    run(AD, 32'h4180_0000, 32'h4180_0000, 32'h4210_0000, 4'h4);
    run(AD, 32'h4210_0000, 32'h4110_0000, 32'h4211_0000, 4'h4);
    run(AD, 32'h4110_0000, 32'h4210_0000, 32'h4211_0000, 4'h4);
    run(AD, 32'h4710_0000, 32'h4180_0000, 32'h4710_0001, 4'h4);
    run(AD, 32'h4810_0000, 32'h4180_0000, 32'h4810_0000, 4'h4);
    run(SB, 32'h4110_0000, 32'h4810_0000, 32'hB7F0_0000, 4'h2);
    run(SB, 32'h4180_0000, 32'h4180_0000, 32'h0000_0000, 4'h1);
    run(SB, 32'h4140_0000, 32'h4180_0000, 32'hBEC0_0000, 4'h2);
    run(AD, 32'hBEC0_0000, 32'h4180_0000, 32'h4140_0000, 4'h4);
    run(AD, 32'hBE80_0000, 32'hBE80_0000, 32'hBDF0_0000, 4'h2);
    run(MU, 32'h4180_0000, 32'h4180_0000, 32'h4240_0000, 4'h4);
    run(MU, 32'hBE80_0000, 32'h4180_0000, 32'hBDC0_0000, 4'h2);
    go(AD, 1'b1, 64'h4110_0000_0000_0001, 64'h4110_0000_0000_0001,
       64'h4120_0000_0000_0002, 4'h4, 0);
    go(SB, 1'b1, 64'h4110_0000_0000_0000, 64'h4120_0000_0000_0000,
       64'hBEF0_0000_0000_0000, 4'h2, 0);
    go(AD, 1'b1, 64'h4E10_0000_0000_0000, 64'h4110_0000_0000_0000,
       64'h4E10_0000_0000_0001, 4'h4, 0);
    go(AD, 1'b1, 64'h4F10_0000_0000_0000, 64'h4110_0000_0000_0000,
       64'h4F10_0000_0000_0000, 4'h4, 0);
    go(SB, 1'b1, 64'h4110_0000_0000_0001, 64'h4110_0000_0000_0001,
       64'h0000_0000_0000_0000, 4'h1, 0);
    no_res = 1'b1;
    run(MU, 32'h7F80_0000, 32'h7F80_0000, 32'h0000_0000, 4'hD);
    run(MU, 32'h8080_0000, 32'h7F80_0000, 32'h0000_0000, 4'hB);
    run(MU, 32'h0180_0000, 32'h0180_0000, 32'h0000_0000, 4'hC);
    no_res = 1'b0;
    complete_run();
  end
endmodule : hfa_unit_tb_top
